/* dv/ddrpr_core_tb.sv */
// Self-checking bench for the DDR2 command-level device core.
// Assumes the controller model puts every command on the pins.

`timescale 1ns/1ps
`default_nettype none

module ddrpr_core_tb
  import ddrpr_pkg::*;
;
  localparam int CL_SET = 3;
  localparam int WR_SET = 3;
  logic clk;
  logic rst;
  ddrpr_pins_t pins;
  ddrpr_cfg_t cfg;
  ddrpr_cmd_t lastCmd;
  logic [NUM_BANKS-1:0] bankOpen;
  logic [NUM_BANKS-1:0] bankBusy;
  ddrpr_pwr_t pwrState;
  logic dllOn;
  logic pdFull;
  logic refBusy;
  logic mrsStrobe;
  logic [BA_W-1:0] refBank;
  logic [BA_W-1:0] mrsSel;
  int checks = 0;
  int mismatches = 0;

  ddrpr_ctl ddrpr_ctl_inst (.clk(clk), .pins(pins));

  ddrpr_core ddrpr_core_inst (.clk(clk), .rst(rst), .pinsIn(pins), .cfgIn(cfg), .lastCmd(lastCmd),
    .bankOpen(bankOpen), .bankBusy(bankBusy), .pwrState(pwrState), .dllOn(dllOn), .pdFull(pdFull),
    .refBusy(refBusy), .refBank(refBank), .mrsStrobe(mrsStrobe), .mrsSel(mrsSel));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Latencies only change while the device is idle and settled.
  task automatic setCfg(input int a, input logic b8, input logic fe, input int c = CL_SET, input int w = WR_SET);
    @(posedge clk);
    cfg <= '{al: a[2:0], cl: c[2:0], wr: w[2:0], bl8: b8, fastExit: fe};
    #1;
  endtask : setCfg

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic tReset();
    // The first edge after release only samples CKE, so the second edge decodes a NOP.
    chk({lastCmd, pwrState, dllOn, pdFull, refBusy, mrsStrobe}, {CMD_NOP, PW_RUN, 4'h8});
    chk({bankOpen, bankBusy}, 16'h0000);
    chk({refBank, mrsSel}, 6'h00);
    $display("reset test done");
  endtask : tReset

  task automatic tDecode();
    ddrpr_cmd_t cmds [7] = '{CMD_MRS, CMD_NOP, CMD_DSL, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE};
    for (int i = 0; i < 7; i++) begin
      ddrpr_ctl_inst.put(cmds[i], 1'b0, (i == 0) ? 3'h5 : 3'h0);
      ddrpr_ctl_inst.gap(1);
      chk(lastCmd, cmds[i]);
      if (i == 0) chk({mrsStrobe, mrsSel}, 4'hd);
      if (i == 3) chk(bankOpen, 8'h01);
      ddrpr_ctl_inst.settle();
    end
    chk({mrsStrobe, mrsSel, bankOpen}, 12'h500);
    ddrpr_ctl_inst.put(CMD_REF, 1'b0, 3'h0);
    ddrpr_ctl_inst.gap(1);
    chk({lastCmd, refBusy, refBank}, {CMD_REF, 4'h9});
    ddrpr_ctl_inst.gap(RFC_CYC);
    chk(refBusy, 1'b0);
    ddrpr_ctl_inst.settle();
    $display("decode test done");
  endtask : tDecode

  // Two latency settings; the precharge starts WL + BL/2 + WR edges after the write.
  task automatic tWrAp();
    int d;
    for (int j = 0; j < 2; j++) begin
      setCfg(0, 1'b0, 1'b1, CL_SET + j, WR_SET + j);
      d = 0 + (CL_SET + j) - 1 + 2 + (WR_SET + j);
      ddrpr_ctl_inst.put(CMD_ACT, 1'b0, 3'h2);
      ddrpr_ctl_inst.put(CMD_WR, 1'b1, 3'h2);
      ddrpr_ctl_inst.gap(d);
      chk({bankOpen[2], bankBusy[2]}, 2'h2);
      ddrpr_ctl_inst.gap(1);
      chk({bankOpen[2], bankBusy[2]}, 2'h1);
      ddrpr_ctl_inst.gap(RP_CYC);
      chk({bankOpen, bankBusy}, 16'h0000);
      ddrpr_ctl_inst.settle();
    end
    setCfg(0, 1'b0, 1'b1);
    $display("write auto-precharge test done");
  endtask : tWrAp

  // First pass is held back by the row-active time, second by burst and read lockout;
  // the third reads long after activation, so only burst and read lockout decide, and they tie.
  task automatic tRdAp();
    int e;
    int a;
    for (int k = 0; k < 3; k++) begin
      a = k % 2;
      setCfg(a, a[0], 1'b1);
      e = (k == 2) ? 0 : RAS_CYC - 1;
      if (3 * a + 2 > e) e = 3 * a + 2;
      if (3 * a + RTP_EFF > e) e = 3 * a + RTP_EFF;
      ddrpr_ctl_inst.put(CMD_ACT, 1'b0, 3'h3);
      if (k == 2) ddrpr_ctl_inst.gap(RAS_CYC);
      ddrpr_ctl_inst.put(CMD_RD, 1'b1, 3'h3);
      ddrpr_ctl_inst.gap(e);
      chk({bankOpen[3], bankBusy[3]}, 2'h2);
      ddrpr_ctl_inst.gap(1);
      chk({bankOpen[3], bankBusy[3]}, 2'h1);
      ddrpr_ctl_inst.settle();
    end
    setCfg(0, 1'b0, 1'b1);
    $display("read auto-precharge test done");
  endtask : tRdAp

  task automatic tPre();
    ddrpr_ctl_inst.put(CMD_ACT, 1'b0, 3'h1);
    ddrpr_ctl_inst.put(CMD_ACT, 1'b0, 3'h5);
    ddrpr_ctl_inst.gap(RAS_CYC);
    ddrpr_ctl_inst.put(CMD_PRE, 1'b0, 3'h1);
    ddrpr_ctl_inst.put(CMD_PRE, 1'b1, 3'h6);
    ddrpr_ctl_inst.gap(1);
    chk({bankOpen, bankBusy}, 16'h0022);
    ddrpr_ctl_inst.gap(RP_CYC);
    chk(bankBusy, 8'h22);
    ddrpr_ctl_inst.gap(1);
    chk(bankBusy, 8'h00);
    ddrpr_ctl_inst.settle();
    $display("precharge test done");
  endtask : tPre

  task automatic tPwr();
    int n;
    ddrpr_ctl_inst.put(CMD_REF, 1'b0, 3'h0);
    ddrpr_ctl_inst.pdEnter(CMD_NOP);
    chk({pwrState, dllOn, pdFull, refBusy}, {PW_PPD, 3'h1});
    n = 0;
    while (pdFull !== 1'b1 && n < RFC_CYC + 2) begin
      ddrpr_ctl_inst.gap(1);
      n++;
    end
    chk({pdFull, refBusy}, 2'h2);
    if (pdFull !== 1'b1) conclude();
    ddrpr_ctl_inst.pdExit();
    chk({pwrState, dllOn}, {PW_RUN, 1'b1});
    ddrpr_ctl_inst.put(CMD_ACT, 1'b0, 3'h4);
    ddrpr_ctl_inst.gap(1);
    for (int f = 1; f >= 0; f--) begin
      setCfg(0, 1'b0, f[0]);
      ddrpr_ctl_inst.pdEnter(CMD_NOP);
      chk({pwrState, dllOn, bankOpen}, {PW_APD, f[0], 8'h10});
      ddrpr_ctl_inst.pdExit();
      chk({pwrState, dllOn}, {PW_RUN, 1'b1});
    end
    ddrpr_ctl_inst.put(CMD_PRE, 1'b0, 3'h4);
    ddrpr_ctl_inst.settle();
    ddrpr_ctl_inst.pdEnter(CMD_REF);
    chk({pwrState, dllOn, refBank}, {PW_SREF, 4'h3});
    ddrpr_ctl_inst.pdExit();
    chk(pwrState, PW_RUN);
    ddrpr_ctl_inst.settle();
    $display("power-down test done");
  endtask : tPwr

  // ---------------------------------------------------------------------------
  // Clock, reset and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    $display("Error at %0t: run limit reached", $time);
    conclude();
  end

  initial begin
    rst = 1'b1;
    cfg = '{al: 3'h0, cl: CL_SET[2:0], wr: WR_SET[2:0], bl8: 1'b0, fastExit: 1'b1};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ddrpr_ctl_inst.gap(2);
    tReset();
    tDecode();
    tWrAp();
    tRdAp();
    tPre();
    tPwr();
    conclude();
  end
endmodule : ddrpr_core_tb

`default_nettype wire

/* dv/ddrpr_ctl.sv */
// Memory-controller model that drives the DDR2 command pins of the device.
// Assumes callers enter its tasks just after a rising clock edge.

`timescale 1ns/1ps
`default_nettype none

module ddrpr_ctl
  import ddrpr_pkg::*;
(
  input wire logic clk,
  output var ddrpr_pins_t pins
);
  logic ckeLvl = 1'b1;

  initial pins = '{cke: 1'b1, csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, a10: 1'b0, ba: '0};

  // ---------------------------------------------------------------------------
  // Command issue
  // ---------------------------------------------------------------------------
  // Address pins are don't-care on NOP and deselect, so they toggle rather than
  // hold a value that the device might wrongly rely on.
  task automatic put(input ddrpr_cmd_t c, input logic a10, input logic [BA_W-1:0] ba);
    logic idle;
    idle = (c == CMD_NOP) || (c == CMD_DSL);
    @(posedge clk);
    pins <= '{cke: ckeLvl, csN: c[3], rasN: c[2], casN: c[1], weN: c[0],
      a10: idle ? ~pins.a10 : a10, ba: idle ? ~pins.ba : ba};
  endtask : put

  task automatic gap(input int n);
    repeat (n) put(CMD_NOP, 1'b0, '0);
    #1;
  endtask : gap

  // One idle stretch covers every burst, precharge and refresh spacing at the
  // latencies used here; it trades run time for a single safe figure.
  task automatic settle();
    gap(16);
  endtask : settle

  // ---------------------------------------------------------------------------
  // Power-down entry and exit
  // ---------------------------------------------------------------------------
  task automatic pdEnter(input ddrpr_cmd_t c);
    ckeLvl = 1'b0;
    put(c, 1'b0, '0);
    gap(2);
  endtask : pdEnter

  // The clock keeps running at one rate; no frequency change is ever made.
  task automatic pdExit();
    gap(3);
    ckeLvl = 1'b1;
    gap(2);
  endtask : pdExit
endmodule : ddrpr_ctl

`default_nettype wire

/* hdl/ddrpr_bank.sv */
// One bank's open/precharge tracker with auto-precharge scheduling.
// Assumes hit strobes already qualified by the command decoder.

`timescale 1ns/1ps
`default_nettype none

module ddrpr_bank
  import ddrpr_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic actHit,
  input wire logic rdHit,
  input wire logic wrHit,
  input wire logic apFlag,
  input wire logic preHit,
  input wire logic preAll,
  input wire logic [CW-1:0] apRdLoad,
  input wire logic [CW-1:0] apWrLoad,
  input wire logic [CW-1:0] rtpLoad,
  output ddrpr_bank_t state
);

  ddrpr_bank_t state_reg, state_next;
  logic [CW-1:0] rasCnt_reg, rtpCnt_reg, apCnt_reg, preCnt_reg;
  logic [CW-1:0] rasCnt_next, rtpCnt_next, apCnt_next, preCnt_next;
  logic apPend_reg, apPend_next;

  function automatic logic [CW-1:0] dn(input logic [CW-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction : dn

  // ---------------------------------------------------------------------------
  // Scheduling
  // ---------------------------------------------------------------------------
  wire isIdle = state_reg == BK_IDLE;
  wire isAct = state_reg == BK_ACTIVE;
  wire colHit = (rdHit || wrHit) && isAct;
  // Auto-precharge waits for its delay and also for tRAS and tRTP lockout.
  wire apGo = isAct && apPend_reg && apCnt_reg == '0 && rasCnt_reg == '0 && rtpCnt_reg == '0;
  wire preGo = preHit && !isIdle;
  wire startPre = apGo || preGo;
  wire [CW-1:0] preLoad = (preGo && preAll) ? CW'(RP_CYC) : CW'(RP_CYC - 1);

  assign state_next = startPre ? BK_PRE :
                      (actHit && isIdle) ? BK_ACTIVE :
                      (state_reg == BK_PRE && preCnt_reg == '0) ? BK_IDLE : state_reg;
  assign rasCnt_next = (actHit && isIdle) ? CW'(RAS_CYC - 1) : dn(rasCnt_reg);
  assign rtpCnt_next = (rdHit && isAct) ? rtpLoad : dn(rtpCnt_reg);
  assign apPend_next = startPre ? 1'b0 : (colHit && apFlag) ? 1'b1 : apPend_reg;
  assign apCnt_next = (colHit && apFlag) ? (rdHit ? apRdLoad : apWrLoad) : dn(apCnt_reg);
  assign preCnt_next = startPre ? preLoad : dn(preCnt_reg);
  assign state = state_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= BK_IDLE;
      rasCnt_reg <= '0;
      rtpCnt_reg <= '0;
      apCnt_reg <= '0;
      preCnt_reg <= '0;
      apPend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rasCnt_reg <= rasCnt_next;
      rtpCnt_reg <= rtpCnt_next;
      apCnt_reg <= apCnt_next;
      preCnt_reg <= preCnt_next;
      apPend_reg <= apPend_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_apStart;
    isAct && apPend_reg && apCnt_reg == '0 && rasCnt_reg == '0 && rtpCnt_reg == '0 |=> state_reg == BK_PRE;
  endproperty
  a_apStart: assert property (p_apStart) else $error("auto-precharge did not start");

  property p_rasLock;
    isAct && apPend_reg && rasCnt_reg != '0 && !preHit |=> state_reg == BK_ACTIVE;
  endproperty
  a_rasLock: assert property (p_rasLock) else $error("auto-precharge ignored tRAS");

  property p_rdApDelay;
    rdHit && apFlag && isAct && apRdLoad == CW'(1) && rtpLoad == CW'(1) && rasCnt_reg <= CW'(2)
      ##1 (!preHit)[*2] |=> state_reg == BK_PRE;
  endproperty
  a_rdApDelay: assert property (p_rdApDelay) else $error("read auto-precharge late");

  // Repetition counts follow RP_CYC of two: precharge-all stays busy one cycle longer than a single bank.
  property p_preAllLen;
    preHit && preAll && !isIdle ##1 (!preHit)[*3] |-> state_reg == BK_PRE ##1 state_reg == BK_IDLE;
  endproperty
  a_preAllLen: assert property (p_preAllLen) else $error("precharge-all period wrong");

  property p_preOneLen;
    preHit && !preAll && !isIdle ##1 (!preHit)[*2] |-> state_reg == BK_PRE ##1 state_reg == BK_IDLE;
  endproperty
  a_preOneLen: assert property (p_preOneLen) else $error("single precharge period wrong");

  c_apStart: cover property (apGo);

endmodule : ddrpr_bank

`default_nettype wire

/* hdl/ddrpr_core.sv */
// DDR2 device command decoder, bank tracking, refresh and power-state control.
// Assumes pins are sampled on the rising clock edge and are synchronous to clk;
// latency settings arrive on cfgIn and are held steady by the surroundings.

`timescale 1ns/1ps
`default_nettype none

module ddrpr_core
  import ddrpr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ddrpr_pins_t pinsIn,
  input wire ddrpr_cfg_t cfgIn,
  output ddrpr_cmd_t lastCmd,
  output logic [NUM_BANKS-1:0] bankOpen,
  output logic [NUM_BANKS-1:0] bankBusy,
  output ddrpr_pwr_t pwrState,
  output logic dllOn,
  output logic pdFull,
  output logic refBusy,
  output logic [BA_W-1:0] refBank,
  output logic mrsStrobe,
  output logic [BA_W-1:0] mrsSel
);

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  logic ckePrev_reg;
  wire [2:0] rcw = {pinsIn.rasN, pinsIn.casN, pinsIn.weN};
  // The unused LHHL code carries no operation here and is treated as a no-op.
  wire ddrpr_cmd_t code = pinsIn.csN ? CMD_DSL :
                          (rcw == 3'h6) ? CMD_NOP : ddrpr_cmd_t'({1'b0, rcw});
  wire cmdValid = ckePrev_reg && pinsIn.cke;
  wire isNopDsl = code == CMD_NOP || code == CMD_DSL;
  wire ckeFall = ckePrev_reg && !pinsIn.cke;
  wire ckeRise = !ckePrev_reg && pinsIn.cke;
  wire actCmd = cmdValid && code == CMD_ACT;
  wire rdCmd = cmdValid && code == CMD_RD;
  wire wrCmd = cmdValid && code == CMD_WR;
  wire preCmd = cmdValid && code == CMD_PRE;
  wire refCmd = cmdValid && code == CMD_REF;
  wire mrsCmd = cmdValid && code == CMD_MRS;

  // ---------------------------------------------------------------------------
  // Latency arithmetic shared by all banks
  // ---------------------------------------------------------------------------
  wire [CNT_W-1:0] alW = CNT_W'(cfgIn.al);
  wire [CNT_W-1:0] clW = CNT_W'(cfgIn.cl);
  wire [CNT_W-1:0] wrW = CNT_W'(cfgIn.wr);
  wire [CNT_W-1:0] blHalf = cfgIn.bl8 ? CNT_W'(BL8_HALF) : CNT_W'(BL4_HALF);
  wire [CNT_W-1:0] lastPf = cfgIn.bl8 ? CNT_W'(BL8_PREFETCH) : '0;
  wire [CNT_W-1:0] apRdLoad = alW + blHalf - 1'b1;
  // Write latency is AL + CL - 1, so the burst plus WR ends at AL+CL+BL/2+WR-1.
  wire [CNT_W-1:0] apWrLoad = alW + clW + blHalf + wrW - CNT_W'(2);
  wire [CNT_W-1:0] rtpLoad = alW + lastPf + CNT_W'(RTP_EFF - 1);

  // ---------------------------------------------------------------------------
  // Banks
  // ---------------------------------------------------------------------------
  ddrpr_bank_t bankState [NUM_BANKS];
  logic [NUM_BANKS-1:0] bankIdle;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      wire baHit = pinsIn.ba == BA_W'(gi);
      ddrpr_bank #(
        .CW(CNT_W)
      ) ddrpr_bank_inst (
        .clk(clk),
        .rst(rst),
        .actHit(actCmd && baHit),
        .rdHit(rdCmd && baHit),
        .wrHit(wrCmd && baHit),
        .apFlag(pinsIn.a10),
        .preHit(preCmd && (pinsIn.a10 || baHit)),
        .preAll(pinsIn.a10),
        .apRdLoad(apRdLoad),
        .apWrLoad(apWrLoad),
        .rtpLoad(rtpLoad),
        .state(bankState[gi])
      );
      assign bankOpen[gi] = bankState[gi] == BK_ACTIVE;
      assign bankBusy[gi] = bankState[gi] == BK_PRE;
      assign bankIdle[gi] = bankState[gi] == BK_IDLE;
    end
  endgenerate

  wire anyOpen = |bankOpen;
  wire allIdle = &bankIdle;

  // ---------------------------------------------------------------------------
  // Refresh and mode register select
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] rfcCnt_reg;
  logic [BA_W-1:0] refBank_reg, mrsSel_reg;
  logic mrsStrobe_reg;
  ddrpr_cmd_t lastCmd_reg;

  wire srefEnter = ckeFall && code == CMD_REF && allIdle;
  wire refStart = refCmd || srefEnter;
  // The refreshed bank comes from an internal counter, not from the pins.
  wire [BA_W-1:0] refBank_next = refStart ? refBank_reg + 1'b1 : refBank_reg;
  wire [CNT_W-1:0] rfcCnt_next = refStart ? CNT_W'(RFC_CYC - 1) :
                                 (rfcCnt_reg == '0) ? rfcCnt_reg : rfcCnt_reg - 1'b1;
  wire [BA_W-1:0] mrsSel_next = mrsCmd ? pinsIn.ba : mrsSel_reg;
  wire ddrpr_cmd_t lastCmd_next = cmdValid ? code : CMD_DSL;

  // ---------------------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------------------
  ddrpr_pwr_t pwr_reg, pwr_next;
  logic dllOn_reg, pdFull_reg;

  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PW_RUN: begin
        if (srefEnter) begin
          pwr_next = PW_SREF;
        end else if (ckeFall && isNopDsl) begin
          pwr_next = anyOpen ? PW_APD : PW_PPD;
        end
      end
      PW_PPD, PW_APD: begin
        if (ckeRise && isNopDsl) begin
          pwr_next = PW_RUN;
        end
      end
      PW_SREF: begin
        // Exit is taken on the first sampled CKE high, with no clock count.
        if (pinsIn.cke && isNopDsl) begin
          pwr_next = PW_RUN;
        end
      end
    endcase
  end

  wire dllOn_next = !(pwr_next == PW_PPD || pwr_next == PW_SREF ||
                      (pwr_next == PW_APD && !cfgIn.fastExit));
  // Deep power-down waits for precharges and refreshes already under way.
  wire pdFull_next = pwr_next != PW_RUN && !(|bankBusy) && rfcCnt_next == '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ckePrev_reg <= 1'b0;
      pwr_reg <= PW_RUN;
      dllOn_reg <= 1'b1;
      pdFull_reg <= 1'b0;
      rfcCnt_reg <= '0;
      refBank_reg <= '0;
      mrsSel_reg <= '0;
      mrsStrobe_reg <= 1'b0;
      lastCmd_reg <= CMD_DSL;
    end else begin
      ckePrev_reg <= pinsIn.cke;
      pwr_reg <= pwr_next;
      dllOn_reg <= dllOn_next;
      pdFull_reg <= pdFull_next;
      rfcCnt_reg <= rfcCnt_next;
      refBank_reg <= refBank_next;
      mrsSel_reg <= mrsSel_next;
      mrsStrobe_reg <= mrsCmd;
      lastCmd_reg <= lastCmd_next;
    end
  end

  assign pwrState = pwr_reg;
  assign dllOn = dllOn_reg;
  assign pdFull = pdFull_reg;
  assign refBusy = rfcCnt_reg != '0;
  assign refBank = refBank_reg;
  assign mrsStrobe = mrsStrobe_reg;
  assign mrsSel = mrsSel_reg;
  assign lastCmd = lastCmd_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_decode;
    cmdValid && !pinsIn.csN && rcw == 3'h3 |=> lastCmd_reg == CMD_ACT;
  endproperty
  a_decode: assert property (p_decode) else $error("activate not decoded");

  property p_preAllBanks;
    preCmd && pinsIn.a10 |=> !(|bankOpen);
  endproperty
  a_preAllBanks: assert property (p_preAllBanks) else $error("precharge-all left a bank open");

  property p_mrsSel;
    mrsCmd |=> mrsStrobe_reg && mrsSel_reg == $past(pinsIn.ba);
  endproperty
  a_mrsSel: assert property (p_mrsSel) else $error("mode register select wrong");

  property p_srefIn;
    pwr_reg == PW_RUN && srefEnter |=> pwr_reg == PW_SREF && refBusy;
  endproperty
  a_srefIn: assert property (p_srefIn) else $error("self refresh not entered");

  property p_srefOut;
    pwr_reg == PW_SREF && pinsIn.cke && isNopDsl |=> pwr_reg == PW_RUN ##1 dllOn_reg;
  endproperty
  a_srefOut: assert property (p_srefOut) else $error("self refresh not left");

  property p_pdKind;
    pwr_reg == PW_RUN && ckeFall && isNopDsl && !srefEnter |=>
      pwr_reg == ($past(anyOpen) ? PW_APD : PW_PPD);
  endproperty
  a_pdKind: assert property (p_pdKind) else $error("power-down kind wrong");

  property p_dll;
    pwr_reg == PW_PPD || (pwr_reg == PW_APD && !cfgIn.fastExit) |-> !dllOn_reg;
  endproperty
  a_dll: assert property (p_dll) else $error("DLL left on in power-down");

  property p_pdWait;
    pwr_reg != PW_RUN && refBusy |-> !pdFull_reg;
  endproperty
  a_pdWait: assert property (p_pdWait) else $error("full power-down too early");

  property p_pdFull;
    pwr_reg != PW_RUN && pwr_next != PW_RUN && (|bankBusy) |=> !pdFull_reg;
  endproperty
  a_pdFull: assert property (p_pdFull) else $error("power-down reached with precharge pending");

  property p_refCount;
    refCmd |=> refBank_reg == $past(refBank_reg) + 1'b1 ##0 refBusy[*2];
  endproperty
  a_refCount: assert property (p_refCount) else $error("refresh bank counter stuck");

  c_sref: cover property (srefEnter);
  c_apd: cover property (pwr_reg == PW_APD && dllOn_reg);
  c_ppdFull: cover property (pwr_reg == PW_PPD && pdFull_reg);
  c_preAll: cover property (preCmd && pinsIn.a10 && anyOpen);

endmodule : ddrpr_core

`default_nettype wire

/* hdl/ddrpr_pkg.sv */
// Shared types and constants for the DDR2 command-level device model.
// Assumes one 100 MHz clock; all timing figures below are minimum times.

package ddrpr_pkg;

  // ---------------------------------------------------------------------------
  // Clock and analog timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PS = 10000;
  localparam int T_RAS_PS = 45000;
  localparam int T_RTP_PS = 7500;
  localparam int T_RP_PS = 15000;
  localparam int T_RFC_PS = 127500;
  // Least times round up to whole cycles.
  localparam int RAS_CYC = (T_RAS_PS + CLK_PS - 1) / CLK_PS;
  localparam int RTP_CYC = (T_RTP_PS + CLK_PS - 1) / CLK_PS;
  localparam int RP_CYC = (T_RP_PS + CLK_PS - 1) / CLK_PS;
  localparam int RFC_CYC = (T_RFC_PS + CLK_PS - 1) / CLK_PS;
  localparam int RTP_FLOOR = 2;
  localparam int RTP_EFF = (RTP_CYC > RTP_FLOOR) ? RTP_CYC : RTP_FLOOR;

  // ---------------------------------------------------------------------------
  // Geometry and field layout
  // ---------------------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int BA_W = 3;
  localparam int CNT_W = 6;
  localparam int BL4_HALF = 2;
  localparam int BL8_HALF = 4;
  localparam int BL8_PREFETCH = 2;

  // Command code is {csN, rasN, casN, weN}.
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_NOP = 4'h7,
    CMD_DSL = 4'h8
  } ddrpr_cmd_t;

  typedef enum logic [1:0] {
    BK_IDLE = 2'h0,
    BK_ACTIVE = 2'h1,
    BK_PRE = 2'h3
  } ddrpr_bank_t;

  typedef enum logic [1:0] {
    PW_RUN = 2'h0,
    PW_PPD = 2'h1,
    PW_APD = 2'h2,
    PW_SREF = 2'h3
  } ddrpr_pwr_t;

  typedef struct packed {
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic a10;
    logic [BA_W-1:0] ba;
  } ddrpr_pins_t;

  typedef struct packed {
    logic [2:0] al;
    logic [2:0] cl;
    logic [2:0] wr;
    logic bl8;
    logic fastExit;
  } ddrpr_cfg_t;

endpackage : ddrpr_pkg
